// >>> hdl/rerc_core.sv
// Module: key-switch error reset, role-change output check and channel configuration
`timescale 1ns/1ps
// Operation
// - Reserve keeps output faults until manual clear
// - Cleared reserve becomes eligible for master again
// - New master rechecks outputs within 12.66 ms
// - Forced role change triggers error status check
// - Clear starts only as reserve with fault
// - Flash user indicator while key held
// - Configuration accepted only from fieldbus initialization
// - Partner parameter defaults to no partner
// - Each analog input has own range
// - Only inputs one to six accept voltage
module rerc_core
#(
  // Timing counts; the bench shortens them
  parameter int unsigned HOLD_CYCLES  = rerc_pkg::HOLD_CYCLES,
  parameter int unsigned BLINK_CYCLES = rerc_pkg::BLINK_CYCLES,
  parameter int unsigned CHECK_CYCLES = rerc_pkg::CHECK_CYCLES
)
(
  // Clock and reset
  input  wire logic                                 core_clk_in,
  input  wire logic                                 reset_in,
  // Operator and redundancy pins
  input  wire rerc_pkg::rerc_key_t                  key_switch_in,
  input  wire logic                                 is_master_in,
  input  wire logic                                 output_fault_in,
  input  wire logic                                 output_ok_in,
  // Fieldbus configuration
  input  wire rerc_pkg::rerc_cfg_t                  cfg_in,
  // Indicators and status
  output logic                                      external_fault_indicator_out,
  output logic                                      user_indicator_one_out,
  output logic                                      master_eligible_out,
  output logic                                      output_check_busy_out,
  output logic                                      cfg_error_out,
  output logic [rerc_pkg::PARTNER_W-1:0]            partner_addr_out,
  output logic [rerc_pkg::AI_CHANNELS*rerc_pkg::RANGE_W-1:0] ai_range_out
);

  // ==========================================================
  // State
  // ==========================================================
  rerc_pkg::rerc_state_t state_reg;
  rerc_pkg::rerc_state_t state_next;

  // Counter width for the size casts
  localparam int unsigned CNT_W = rerc_pkg::CNT_W;

  logic                        key_mem_reset;
  logic                        key_run;
  logic                        fault_s;
  logic                        master_s;
  logic                        ok_s;
  logic                        role_up;
  logic                        cfg_take;
  logic                        range_ok;
  logic [rerc_pkg::CH_IDX_W-1:0] ch;

  assign key_mem_reset = (state_reg.key_s2 == 2'(rerc_pkg::KEY_MEM_RESET));
  assign key_run  = (state_reg.key_s2 == 2'(rerc_pkg::KEY_RUN)) || (state_reg.key_s2 == 2'(rerc_pkg::KEY_RUN_P));
  assign master_s = state_reg.ext_s2[0];
  assign fault_s  = state_reg.ext_s2[1];
  assign ok_s     = state_reg.ext_s2[2];
  assign role_up  = master_s && !state_reg.master_d;
  assign ch       = cfg_in.channel;

  // Voltage ranges only on the lower channels
  assign range_ok = (cfg_in.range <= rerc_pkg::RANGE_CUR_PM30) ||
                    ((cfg_in.range <= rerc_pkg::RANGE_VOLT_0_10) &&
                     (32'(ch) < rerc_pkg::AI_VOLT_CHANNELS));
  assign cfg_take = cfg_in.valid && cfg_in.init_phase;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    state_next        = state_reg;
    state_next.key_s1 = key_switch_in;
    state_next.key_s2 = state_reg.key_s1;
    state_next.ext_s1 = {output_ok_in, output_fault_in, is_master_in};
    state_next.ext_s2 = state_reg.ext_s1;
    state_next.master_d = master_s;

    // Latch faults; the reserve never clears them itself
    if (fault_s && master_s)
    begin
      state_next.fault_stored = 1'b1;
      state_next.eligible     = 1'b0;
    end
    else if (fault_s && !master_s && !state_reg.fault_stored && state_reg.clr == rerc_pkg::CLR_IDLE)
    begin
      state_next.fault_stored = 1'b1;
      state_next.eligible     = 1'b0;
    end

    // Role gained, forced or not: run the output check
    if (role_up)
    begin
      state_next.checking  = 1'b1;
      state_next.check_cnt = '0;
    end
    else if (state_reg.checking)
    begin
      if (state_reg.check_cnt >= CNT_W'(CHECK_CYCLES - 1))
      begin
        state_next.checking     = 1'b0;
        state_next.fault_stored = fault_s;
        state_next.eligible     = !fault_s;
      end
      else if (ok_s && !fault_s)
      begin
        state_next.checking     = 1'b0;
        state_next.fault_stored = 1'b0;
        state_next.eligible     = 1'b1;
      end
      else
      begin
        state_next.check_cnt = state_reg.check_cnt + 1'b1;
      end
    end

    // Key clear sequence
    unique case (state_reg.clr)
      rerc_pkg::CLR_IDLE:
      begin
        state_next.blink = 1'b0;
        if (key_mem_reset && !master_s && state_reg.fault_stored)
        begin
          state_next.clr       = rerc_pkg::CLR_HOLD;
          state_next.hold_cnt  = '0;
          state_next.blink_cnt = '0;
        end
      end
      rerc_pkg::CLR_HOLD:
      begin
        if (!key_mem_reset || master_s)
        begin
          state_next.clr   = rerc_pkg::CLR_IDLE;
          state_next.blink = 1'b0;
        end
        else if (state_reg.hold_cnt >= CNT_W'(HOLD_CYCLES - 1))
        begin
          state_next.clr          = rerc_pkg::CLR_WAIT;
          state_next.fault_stored = 1'b0;
          state_next.eligible     = 1'b1;
          state_next.blink        = 1'b0;
        end
        else
        begin
          state_next.hold_cnt = state_reg.hold_cnt + 1'b1;
          if (state_reg.blink_cnt >= CNT_W'(BLINK_CYCLES - 1))
          begin
            state_next.blink_cnt = '0;
            state_next.blink     = !state_reg.blink;
          end
          else
          begin
            state_next.blink_cnt = state_reg.blink_cnt + 1'b1;
          end
        end
      end
      rerc_pkg::CLR_WAIT:
      begin
        if (key_run)
        begin
          state_next.clr = rerc_pkg::CLR_IDLE;
        end
      end
      default:
      begin
        state_next.clr = rerc_pkg::CLR_IDLE;
      end
    endcase

    // Fieldbus parameter load
    state_next.cfg_err = 1'b0;
    if (cfg_take)
    begin
      if (cfg_in.is_partner)
      begin
        state_next.partner = cfg_in.partner;
      end
      else if (range_ok && 32'(ch) < rerc_pkg::AI_CHANNELS)
      begin
        state_next.ranges[32'(ch)*rerc_pkg::RANGE_W +: rerc_pkg::RANGE_W] = cfg_in.range;
      end
      else
      begin
        state_next.cfg_err = 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      state_reg              <= '0;
      state_reg.clr          <= rerc_pkg::CLR_IDLE;
      state_reg.eligible     <= 1'b1;
      state_reg.partner      <= rerc_pkg::PARTNER_NONE;
      state_reg.ranges       <= {rerc_pkg::AI_CHANNELS{rerc_pkg::RANGE_RESET}};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign external_fault_indicator_out = state_reg.fault_stored;
  assign user_indicator_one_out       = state_reg.blink;
  assign master_eligible_out          = state_reg.eligible;
  assign output_check_busy_out        = state_reg.checking;
  assign cfg_error_out                = state_reg.cfg_err;
  assign partner_addr_out             = state_reg.partner;
  assign ai_range_out                 = state_reg.ranges;

  // ==========================================================
  // Checks
  // ==========================================================
  chk_idle_no_start: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_reg.clr == rerc_pkg::CLR_IDLE && master_s) |=> state_reg.clr == rerc_pkg::CLR_IDLE)
    else $error("Clear started while master");
  chk_start_needs_fault: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_reg.clr == rerc_pkg::CLR_IDLE && !state_reg.fault_stored) |=> state_reg.clr == rerc_pkg::CLR_IDLE)
    else $error("Clear started without fault");
  chk_early_release: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_reg.clr == rerc_pkg::CLR_HOLD && !key_mem_reset) |=> state_reg.clr == rerc_pkg::CLR_IDLE && state_reg.fault_stored)
    else $error("Early release did not abandon");
  chk_delete_lamps: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_reg.clr == rerc_pkg::CLR_HOLD && key_mem_reset && !master_s && state_reg.hold_cnt >= CNT_W'(HOLD_CYCLES - 1))
    |=> state_reg.clr == rerc_pkg::CLR_WAIT && !external_fault_indicator_out)
    else $error("Errors not deleted after hold");
  chk_wait_lamps_off: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(state_reg.clr == rerc_pkg::CLR_WAIT) |-> !external_fault_indicator_out && !user_indicator_one_out)
    else $error("Lamps not off after delete");
  chk_eligible_after: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(state_reg.clr == rerc_pkg::CLR_WAIT) |-> master_eligible_out)
    else $error("Not eligible after delete");
  chk_blink_only_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
    user_indicator_one_out |-> state_reg.clr == rerc_pkg::CLR_HOLD)
    else $error("Blink outside hold");
  chk_check_start: assert property (@(posedge core_clk_in) disable iff (reset_in)
    role_up |=> output_check_busy_out)
    else $error("Role change did not start check");
  chk_check_bound: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (output_check_busy_out && state_reg.check_cnt >= CNT_W'(CHECK_CYCLES - 1) && !role_up)
    |=> !output_check_busy_out)
    else $error("Output check overran");
  chk_cfg_init_only: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !cfg_take |=> $stable(state_reg.ranges) && $stable(state_reg.partner))
    else $error("Configuration changed outside init");
  chk_volt_low_only: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (cfg_take && !cfg_in.is_partner && cfg_in.range > rerc_pkg::RANGE_CUR_PM30 &&
     32'(ch) >= rerc_pkg::AI_VOLT_CHANNELS) |=> cfg_error_out)
    else $error("Voltage accepted on high channel");

  chk_volt_accept: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (cfg_take && !cfg_in.is_partner && cfg_in.range > rerc_pkg::RANGE_CUR_PM30 &&
     cfg_in.range <= rerc_pkg::RANGE_VOLT_0_10 && 32'(ch) < rerc_pkg::AI_VOLT_CHANNELS) |=> !cfg_error_out)
    else $error("Voltage refused on low channel");
  chk_partner_default: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $fell(reset_in) |-> partner_addr_out == rerc_pkg::PARTNER_NONE)
    else $error("Partner not none after reset");
  chk_partner_load: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (cfg_take && cfg_in.is_partner) |=> partner_addr_out == $past(cfg_in.partner))
    else $error("Partner write not taken");
  chk_reserve_keeps: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (!master_s && !state_reg.checking && state_reg.clr != rerc_pkg::CLR_HOLD && state_reg.fault_stored)
    |=> external_fault_indicator_out)
    else $error("Reserve cleared fault by itself");
  chk_master_latch: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (master_s && fault_s) |=> external_fault_indicator_out)
    else $error("Master missed output fault");
  chk_wait_for_run: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_reg.clr == rerc_pkg::CLR_WAIT && !key_run) |=> state_reg.clr == rerc_pkg::CLR_WAIT)
    else $error("Clear left wait without run");

  // Main scenarios
  cov_clear_done: cover property (@(posedge core_clk_in) state_reg.clr == rerc_pkg::CLR_WAIT);
  cov_abandon:    cover property (@(posedge core_clk_in) state_reg.clr == rerc_pkg::CLR_HOLD && !key_mem_reset);
  cov_flash:      cover property (@(posedge core_clk_in) user_indicator_one_out);
  cov_role_check: cover property (@(posedge core_clk_in) role_up);
  cov_cfg_load:   cover property (@(posedge core_clk_in) cfg_take && !cfg_in.is_partner);

endmodule

// >>> inc/rerc_pkg.sv
// Package: constants and types for the redundant error reset and configuration block
package rerc_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned HOLD_TIME_MS     = 2000;
  localparam int unsigned HOLD_CYCLES      = HOLD_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned CHECK_TIME_US    = 12660;
  localparam int unsigned CHECK_CYCLES     = (CHECK_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BLINK_TIME_MS    = 250;
  localparam int unsigned BLINK_CYCLES     = BLINK_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W            = 26;

  // ==========================================================
  // Configuration layout
  // ==========================================================
  localparam int unsigned AI_CHANNELS      = 12;
  localparam int unsigned AI_VOLT_CHANNELS = 6;
  localparam int unsigned RANGE_W          = 3;
  localparam int unsigned PARTNER_W        = 8;
  localparam int unsigned CH_IDX_W         = 4;

  localparam logic [RANGE_W-1:0]   RANGE_CUR_4_20   = 3'h0;
  localparam logic [RANGE_W-1:0]   RANGE_CUR_0_20   = 3'h1;
  localparam logic [RANGE_W-1:0]   RANGE_CUR_PM20   = 3'h2;
  localparam logic [RANGE_W-1:0]   RANGE_CUR_PM30   = 3'h3;
  localparam logic [RANGE_W-1:0]   RANGE_VOLT_PM10  = 3'h4;
  localparam logic [RANGE_W-1:0]   RANGE_VOLT_0_10  = 3'h5;
  localparam logic [RANGE_W-1:0]   RANGE_RESET      = 3'h0;
  localparam logic [PARTNER_W-1:0] PARTNER_NONE     = 8'h00;

  // ==========================================================
  // Types
  // ==========================================================
  // Gray coded along the switch travel, so the synchroniser never sees a third code
  typedef enum logic [1:0] {
    KEY_RUN_P     = 2'h0,
    KEY_RUN       = 2'h1,
    KEY_STOP      = 2'h3,
    KEY_MEM_RESET = 2'h2
  } rerc_key_t;

  typedef enum logic [1:0] {
    CLR_IDLE   = 2'h0,
    CLR_HOLD   = 2'h1,
    CLR_WAIT   = 2'h3
  } rerc_clr_t;

  typedef struct packed {
    logic                  valid;
    logic                  init_phase;
    logic [CH_IDX_W-1:0]   channel;
    logic                  is_partner;
    logic [PARTNER_W-1:0]  partner;
    logic [RANGE_W-1:0]    range;
  } rerc_cfg_t;

  typedef struct packed {
    rerc_clr_t                         clr;
    logic [CNT_W-1:0]                  hold_cnt;
    logic [CNT_W-1:0]                  blink_cnt;
    logic                              blink;
    logic                              fault_stored;
    logic                              master_d;
    logic                              checking;
    logic [CNT_W-1:0]                  check_cnt;
    logic                              eligible;
    logic [1:0]                        key_s1;
    logic [1:0]                        key_s2;
    logic [2:0]                        ext_s1;
    logic [2:0]                        ext_s2;
    logic [PARTNER_W-1:0]              partner;
    logic [AI_CHANNELS*RANGE_W-1:0]    ranges;
    logic                              cfg_err;
  } rerc_state_t;

endpackage

// >>> test/redundant_error_reset_config_tb.sv
// Self-checking testbench for the error reset and configuration core
`timescale 1ns/1ps
module redundant_error_reset_config_tb;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  rerc_pkg::rerc_key_t  key = rerc_pkg::KEY_RUN;
  logic                 master = 1'b0;
  logic                 fault = 1'b0;
  logic                 ok = 1'b0;
  rerc_pkg::rerc_cfg_t  cfg;
  logic                 ext_ind;
  logic                 user_ind;
  logic                 eligible;
  logic                 busy;
  logic                 cfg_err;
  logic [7:0]           partner;
  logic [35:0]          ranges;
  logic [35:0]          er;
  int                   bad_count = 0;
  int                   compares = 0;
  int                   ch;

  // Shortened timing so the holds and the check bound fit the run
  localparam int        HOLD_T  = 2000;
  localparam int        BLINK_T = 200;
  localparam int        CHECK_T = 400;

  always #20 clk = ~clk;

  rerc_core
  #(
    .HOLD_CYCLES  (HOLD_T),
    .BLINK_CYCLES (BLINK_T),
    .CHECK_CYCLES (CHECK_T)
  )
  i_dut
  (
    .core_clk_in                  (clk),
    .reset_in                     (rst),
    .key_switch_in                (key),
    .is_master_in                 (master),
    .output_fault_in              (fault),
    .output_ok_in                 (ok),
    .cfg_in                       (cfg),
    .external_fault_indicator_out (ext_ind),
    .user_indicator_one_out       (user_ind),
    .master_eligible_out          (eligible),
    .output_check_busy_out        (busy),
    .cfg_error_out                (cfg_err),
    .partner_addr_out             (partner),
    .ai_range_out                 (ranges)
  );

  rerc_dp_master i_master
  (
    .core_clk_in (clk),
    .cfg_out     (cfg)
  );

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(input logic [35:0] got, input logic [35:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Bounded wait for a level on a design output
  task automatic wait_val(ref logic s, input logic v, input string msg);
    int n;
    n = 0;
    while (s !== v && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    check({35'h0_0000_0000, s}, {35'h0_0000_0000, v}, msg);
  endtask

  task automatic results();
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Tests
  // ==========================================================
  initial
  begin
    cyc(5);
    rst = 1'b0;
    cyc(3);
    check({ext_ind, user_ind, eligible, busy, cfg_err}, 36'h0_0000_0004, "reset flags");
    check({28'h000_0000, partner}, '0, "partner reset");
    check(ranges, '0, "range reset");
    $display("Test reset done");

    i_master.send(1'b1, 4'h0, 1'b1, 8'h05);
    check({28'h000_0000, partner}, 36'h0_0000_0005, "partner write");
    er = '0;
    for (ch = 0; ch < 12; ch++)
    begin
      i_master.send(1'b1, 4'(ch), 1'b0, {5'h00, 3'(ch < 6 ? ch % 6 : ch % 4)});
      er[ch*3 +: 3] = 3'(ch < 6 ? ch % 6 : ch % 4);
      check(ranges, er, "range write");
    end
    // Voltage above channel six, bad codes and bad channels
    for (int i = 0; i < 10; i++)
    begin
      i_master.send(1'b1, 4'(i < 6 ? 6 + i : (i < 8 ? 0 : 12 + 3 * (i - 8))), 1'b0,
                    8'(i < 6 ? 4 + i % 2 : (i < 8 ? i : 0)));
      check({35'h0_0000_0000, cfg_err}, 36'h0_0000_0001, "refused write flag");
      check(ranges, er, "refused write kept");
    end
    i_master.send(1'b0, 4'h1, 1'b0, 8'h04);
    check(ranges, er, "write outside init");
    check({28'h000_0000, partner}, 36'h0_0000_0005, "partner kept");
    $display("Test config done");

    fault = 1'b1;
    wait_val(ext_ind, 1'b1, "fault latch");
    fault = 1'b0;
    cyc(10);
    check({35'h0_0000_0000, ext_ind}, 36'h0_0000_0001, "reserve keeps fault");
    key = rerc_pkg::KEY_MEM_RESET;
    cyc(1000);
    key = rerc_pkg::KEY_RUN;
    cyc(10);
    check({35'h0_0000_0000, ext_ind}, 36'h0_0000_0001, "early release keeps fault");
    $display("Test early release done");

    master = 1'b1;
    wait_val(busy, 1'b1, "check starts");
    cyc(20);
    check({35'h0_0000_0000, busy}, 36'h0_0000_0001, "check running");
    ok = 1'b1;
    wait_val(busy, 1'b0, "check ends");
    cyc(2);
    check({35'h0_0000_0000, ext_ind}, 36'h0_0000_0000, "status corrected");
    fault = 1'b1;
    wait_val(ext_ind, 1'b1, "master fault latch");
    key = rerc_pkg::KEY_MEM_RESET;
    cyc(200);
    check({35'h0_0000_0000, user_ind}, 36'h0_0000_0000, "no flash as master");
    key = rerc_pkg::KEY_RUN;
    cyc(5);
    check({35'h0_0000_0000, ext_ind}, 36'h0_0000_0001, "key ignored as master");
    ok = 1'b0;
    master = 1'b0;
    cyc(5);
    master = 1'b1;
    wait_val(busy, 1'b1, "second check starts");
    cyc(CHECK_T - 10);
    check({35'h0_0000_0000, busy}, 36'h0_0000_0001, "check before bound");
    cyc(20);
    check({35'h0_0000_0000, busy}, 36'h0_0000_0000, "check bound");
    check({ext_ind, eligible}, 36'h0_0000_0002, "fault found by check");
    master = 1'b0;
    $display("Test master role done");
    cyc(5);
    key = rerc_pkg::KEY_MEM_RESET;
    cyc(300);
    check({35'h0_0000_0000, user_ind}, 36'h0_0000_0001, "flash while held");
    cyc(HOLD_T - 200);
    check({ext_ind, user_ind, eligible}, 36'h0_0000_0001, "errors deleted");
    key = rerc_pkg::KEY_STOP;
    cyc(5);
    fault = 1'b0;
    cyc(5);
    key = rerc_pkg::KEY_RUN;
    cyc(5);
    check({ext_ind, user_ind, eligible}, 36'h0_0000_0001, "clear sequence done");
    $display("Test error delete done");
    results();
  end

  initial
  begin
    #(40 * 20000);
    bad_count++;
    results();
  end
endmodule

// >>> test/rerc_dp_master.sv
// Fieldbus master model that downloads channel parameters to the block
`timescale 1ns/1ps
module rerc_dp_master
(
  // Clock
  input  wire logic            core_clk_in,
  // Parameter download
  output rerc_pkg::rerc_cfg_t  cfg_out
);
  initial cfg_out = '0;

  // ==========================================================
  // Download word
  // ==========================================================
  // One word for one cycle; afterwards the data lines are scrambled, not held
  task automatic send(input logic init, input logic [3:0] ch, input logic part, input logic [7:0] val);
    @(negedge core_clk_in);
    cfg_out = '{valid: 1'b1, init_phase: init, channel: ch, is_partner: part, partner: val, range: val[2:0]};
    @(negedge core_clk_in);
    cfg_out = {1'b0, ~cfg_out[$bits(cfg_out)-2:0]};
  endtask
endmodule
